/* verilog/wdt_halt_pkg.sv */
// Shared constants, types and register map of the watchdog, halt and reset controller
package wdt_halt_pkg;

   // Register offsets
   localparam logic [7:0] WDT_CTRL_OFF  = 8'h09;
   localparam logic [7:0] RST_FLAGS_OFF = 8'h0A;
   localparam logic [7:0] INT_CTRL_OFF  = 8'h0B;
   localparam logic [7:0] TMR_CTRL_OFF  = 8'h0E;
   localparam logic [7:0] PA_DATA_OFF   = 8'h12;
   localparam logic [7:0] PA_DIR_OFF    = 8'h13;

   // Reset values and writable masks
   localparam logic [7:0] WDT_CTRL_RST     = 8'h07;
   localparam logic [7:0] INT_CTRL_RST     = 8'h00;
   localparam logic [7:0] INT_CTRL_RW_MASK = 8'h37;
   localparam logic [7:0] TMR_CTRL_RST     = 8'h08;
   localparam logic [7:0] TMR_CTRL_RW_MASK = 8'hDF;
   localparam logic [7:0] PORT_RST         = 8'hFF;

   // Field positions
   localparam int WDT_SEL_LSB = 0;
   localparam int WDT_SEL_W   = 3;
   localparam int TO_BIT      = 5;
   localparam int PD_BIT      = 4;

   // Timing counts in system clock cycles and watchdog divider widths in bits
   localparam int INSTR_DIV       = 4;
   localparam int BASE_DIV_BITS   = 8;
   localparam int PRESC_BITS      = 7;
   localparam int SST_CYCLES      = 1024;
   localparam int OPT_LOAD_CYCLES = 16;

   typedef enum logic [2:0] {
      ST_RESET    = 3'b000,
      ST_OPT_LOAD = 3'b001,
      ST_STARTUP  = 3'b010,
      ST_RUN      = 3'b011,
      ST_HALT     = 3'b100
   } pm_state_t;

   typedef enum logic [1:0] {
      WAKE_NONE = 2'b00,
      WAKE_PORT = 2'b01,
      WAKE_IRQ  = 2'b10,
      WAKE_WDT  = 2'b11
   } wake_src_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic       wdt_enable;
      logic       src_rc;
      logic       paired_clear;
      logic [7:0] pa_wake_en;
   } opt_t;

   typedef struct packed {
      logic single_clear;
      logic first_clear;
      logic second_clear;
      logic halt;
   } cpu_instr_t;

endpackage : wdt_halt_pkg

/* verilog/wdt_halt_ctrl.sv */
// Watchdog, power-down, wake-up and reset sequencing for the 8-bit core
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module wdt_halt_ctrl #(
   parameter int N_IRQ = 2
) (
   input  wire logic                    clk_sys_in,
   input  wire logic                    sys_rst_in,
   input  wire wdt_halt_pkg::reg_req_t  reg_req_in,
   output logic [7:0]                   rd_data_out,
   input  wire wdt_halt_pkg::opt_t      opt_in,
   input  wire wdt_halt_pkg::cpu_instr_t instr_in,
   input  wire logic                    rc_tick_in,
   input  wire logic                    ext_reset_n_in,
   input  wire logic [7:0]              pa_pins_in,
   input  wire logic [N_IRQ-1:0]        irq_req_in,
   input  wire logic [N_IRQ-1:0]        irq_enabled_in,
   input  wire logic                    stack_full_in,
   output logic                         sys_osc_on_out,
   output logic                         cpu_run_out,
   output logic                         chip_reset_out,
   output logic                         pc_sp_clear_out,
   output logic                         resume_next_out,
   output logic                         irq_take_out,
   output logic                         timeout_flag_out,
   output logic                         powerdown_flag_out,
   output logic [7:0]                   watchdog_control_reg_out,
   output logic [7:0]                   timer_control_reg_out,
   output logic [7:0]                   interrupt_control_reg_out,
   output logic [7:0]                   pa_data_out,
   output logic [7:0]                   pa_dir_out
);
   import wdt_halt_pkg::*;

   localparam int CNT_W = BASE_DIV_BITS + PRESC_BITS;

   function automatic logic [PRESC_BITS-1:0] presc_mask(input logic [WDT_SEL_W-1:0] sel);
      presc_mask = PRESC_BITS'((1 << sel) - 1);
   endfunction : presc_mask

   pm_state_t             state;
   wake_src_t             wake_src;
   logic [1:0]            instr_div;
   logic [CNT_W-1:0]      wdt_cnt;
   logic [10:0]           seq_cnt;
   logic [7:0]            pa_prev;
   logic [N_IRQ-1:0]      irq_masked;
   logic                  seen_first;
   logic                  seen_second;
   logic                  wdt_tick;
   logic                  wdt_ovf;
   logic                  wdt_clear;
   logic                  clear_hit;
   logic                  pin_low;
   logic                  halt_go;
   logic                  port_wake;
   logic                  irq_wake;
   logic                  chip_rst_ev;
   logic                  warm_rst_ev;
   logic [WDT_SEL_W-1:0]  wdt_sel;

   assign pin_low = !ext_reset_n_in;
   assign wdt_sel = watchdog_control_reg_out[WDT_SEL_LSB +: WDT_SEL_W];
   assign halt_go = (state == ST_RUN) && instr_in.halt;

   // Instruction clock only runs while the system oscillator does
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || state == ST_HALT) begin
         instr_div <= 2'h0;
      end else begin
         instr_div <= 2'(instr_div + 2'h1);
      end
   end

   always_comb begin
      wdt_tick = 1'b0;
      if (opt_in.wdt_enable && (state == ST_RUN || state == ST_HALT)) begin
         if (opt_in.src_rc) begin
            wdt_tick = rc_tick_in;
         end else begin
            wdt_tick = (instr_div == 2'(INSTR_DIV - 1)) && (state == ST_RUN);
         end
      end
   end

   // Overflow when base stage wraps and the selected prescale taps are full
   assign wdt_ovf = wdt_tick && (wdt_cnt[BASE_DIV_BITS-1:0] == '1)
                    && ((wdt_cnt[CNT_W-1:BASE_DIV_BITS] & presc_mask(wdt_sel))
                        == presc_mask(wdt_sel));

   always_comb begin
      clear_hit = 1'b0;
      if (opt_in.wdt_enable && state == ST_RUN) begin
         if (!opt_in.paired_clear) begin
            clear_hit = instr_in.single_clear;
         end else begin
            clear_hit = (seen_first || instr_in.first_clear)
                        && (seen_second || instr_in.second_clear);
         end
      end
   end

   assign wdt_clear = pin_low || clear_hit || halt_go;

   // Paired clear progress; cleared only by a completed clear or any reset
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || chip_rst_ev || warm_rst_ev || clear_hit) begin
         seen_first  <= 1'b0;
         seen_second <= 1'b0;
      end else if (opt_in.wdt_enable && opt_in.paired_clear && state == ST_RUN) begin
         if (instr_in.first_clear) begin
            seen_first <= 1'b1;
         end
         if (instr_in.second_clear) begin
            seen_second <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || wdt_clear || wdt_ovf || state != ST_RUN && state != ST_HALT) begin
         wdt_cnt <= '0;
      end else if (wdt_tick) begin
         wdt_cnt <= CNT_W'(wdt_cnt + 1'b1);
      end
   end

   // Wake sources; interrupts pending at halt entry are masked off
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         irq_masked <= '0;
      end else if (halt_go) begin
         irq_masked <= irq_req_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         pa_prev <= 8'hFF;
      end else begin
         pa_prev <= pa_pins_in;
      end
   end

   assign port_wake = |(pa_prev & ~pa_pins_in & opt_in.pa_wake_en);
   assign irq_wake  = |(irq_req_in & ~irq_masked);

   assign chip_rst_ev = pin_low && state != ST_RESET
                        || wdt_ovf && state == ST_RUN;
   assign warm_rst_ev = wdt_ovf && state == ST_HALT;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state    <= ST_OPT_LOAD;
         seq_cnt  <= '0;
         wake_src <= WAKE_NONE;
      end else begin
         case (state)
            ST_RESET: begin
               seq_cnt <= '0;
               if (!pin_low) begin
                  state <= ST_OPT_LOAD;
               end
            end
            ST_OPT_LOAD: begin
               if (pin_low) begin
                  state <= ST_RESET;
               end else if (seq_cnt == 11'(OPT_LOAD_CYCLES - 1)) begin
                  state   <= ST_STARTUP;
                  seq_cnt <= '0;
               end else begin
                  seq_cnt <= 11'(seq_cnt + 11'h1);
               end
            end
            ST_STARTUP: begin
               if (pin_low) begin
                  state <= ST_RESET;
               end else if (seq_cnt == 11'(SST_CYCLES - 1)) begin
                  state    <= ST_RUN;
                  seq_cnt  <= '0;
                  wake_src <= WAKE_NONE;
               end else begin
                  seq_cnt <= 11'(seq_cnt + 11'h1);
               end
            end
            ST_RUN: begin
               seq_cnt <= '0;
               if (chip_rst_ev) begin
                  state <= pin_low ? ST_RESET : ST_OPT_LOAD;
               end else if (halt_go) begin
                  state <= ST_HALT;
               end
            end
            ST_HALT: begin
               seq_cnt <= '0;
               if (pin_low) begin
                  state <= ST_RESET;
               end else if (warm_rst_ev) begin
                  state    <= ST_STARTUP;
                  wake_src <= WAKE_WDT;
               end else if (irq_wake) begin
                  state    <= ST_STARTUP;
                  wake_src <= WAKE_IRQ;
               end else if (port_wake) begin
                  state    <= ST_STARTUP;
                  wake_src <= WAKE_PORT;
               end
            end
            default: begin
               state <= ST_RESET;
            end
         endcase
      end
   end

   // Resume decision made as the dummy wait ends
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         resume_next_out <= 1'b0;
         irq_take_out    <= 1'b0;
      end else begin
         resume_next_out <= 1'b0;
         irq_take_out    <= 1'b0;
         if (state == ST_STARTUP && !pin_low && seq_cnt == 11'(SST_CYCLES - 1)) begin
            if (wake_src == WAKE_PORT) begin
               resume_next_out <= 1'b1;
            end else if (wake_src == WAKE_IRQ) begin
               if (|(irq_req_in & irq_enabled_in) && !stack_full_in) begin
                  irq_take_out <= 1'b1;
               end else begin
                  resume_next_out <= 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         chip_reset_out  <= 1'b1;
         pc_sp_clear_out <= 1'b1;
      end else begin
         chip_reset_out  <= chip_rst_ev;
         pc_sp_clear_out <= chip_rst_ev || warm_rst_ev;
      end
   end

   // Reset-cause flags; hardware events order: reset kinds, halt, clear
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         timeout_flag_out   <= 1'b0;
         powerdown_flag_out <= 1'b0;
      end else if (state == ST_HALT && pin_low) begin
         timeout_flag_out   <= 1'b0;
         powerdown_flag_out <= 1'b1;
      end else if (warm_rst_ev) begin
         timeout_flag_out   <= 1'b1;
         powerdown_flag_out <= 1'b1;
      end else if (wdt_ovf && state == ST_RUN) begin
         timeout_flag_out <= 1'b1;
      end else if (halt_go) begin
         timeout_flag_out   <= 1'b0;
         powerdown_flag_out <= 1'b1;
      end else if (opt_in.wdt_enable && state == ST_RUN && !opt_in.paired_clear
                   && instr_in.single_clear) begin
         powerdown_flag_out <= 1'b0;
      end
   end

   // Register file; defaults reload on every reset but the warm one
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in || chip_rst_ev) begin
         watchdog_control_reg_out  <= WDT_CTRL_RST;
         timer_control_reg_out     <= TMR_CTRL_RST;
         interrupt_control_reg_out <= INT_CTRL_RST;
         pa_data_out               <= PORT_RST;
         pa_dir_out                <= PORT_RST;
      end else if (reg_req_in.wr && state != ST_HALT) begin
         case (reg_req_in.addr)
            WDT_CTRL_OFF: watchdog_control_reg_out <= reg_req_in.wdata;
            TMR_CTRL_OFF: timer_control_reg_out <= reg_req_in.wdata & TMR_CTRL_RW_MASK;
            INT_CTRL_OFF: interrupt_control_reg_out <= reg_req_in.wdata & INT_CTRL_RW_MASK;
            PA_DATA_OFF:  pa_data_out <= reg_req_in.wdata;
            PA_DIR_OFF:   pa_dir_out <= reg_req_in.wdata;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rd_data_out <= 8'h00;
      end else if (reg_req_in.rd) begin
         case (reg_req_in.addr)
            WDT_CTRL_OFF:  rd_data_out <= watchdog_control_reg_out;
            RST_FLAGS_OFF: rd_data_out <= 8'((timeout_flag_out << TO_BIT)
                                             | (powerdown_flag_out << PD_BIT));
            INT_CTRL_OFF:  rd_data_out <= interrupt_control_reg_out;
            TMR_CTRL_OFF:  rd_data_out <= timer_control_reg_out;
            PA_DATA_OFF:   rd_data_out <= pa_data_out;
            PA_DIR_OFF:    rd_data_out <= pa_dir_out;
            default:       rd_data_out <= 8'h00;
         endcase
      end else begin
         rd_data_out <= 8'h00;
      end
   end

   assign sys_osc_on_out = (state != ST_HALT);
   assign cpu_run_out    = (state == ST_RUN);

   // Checks
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   disabled_no_count_a: assert property (!opt_in.wdt_enable |-> !wdt_ovf)
      else $error("watchdog overflowed while disabled");
   halt_instr_stop_a: assert property (!opt_in.src_rc && state == ST_HALT |-> !wdt_tick)
      else $error("instruction-clock watchdog ticked in halt");
   run_ovf_reset_a: assert property (wdt_ovf && state == ST_RUN && !pin_low
      |=> chip_reset_out && timeout_flag_out && state == ST_OPT_LOAD)
      else $error("normal overflow did not chip reset");
   halt_ovf_warm_a: assert property (warm_rst_ev && !pin_low |=> pc_sp_clear_out
      && !chip_reset_out && timeout_flag_out && powerdown_flag_out
      && $stable(watchdog_control_reg_out))
      else $error("halt overflow not a warm reset");
   clear_zeroes_a: assert property (wdt_clear |=> wdt_cnt == '0)
      else $error("watchdog not cleared");
   halt_flags_a: assert property (halt_go && !chip_rst_ev
      |=> powerdown_flag_out && !timeout_flag_out && !sys_osc_on_out)
      else $error("halt flags wrong");
   pending_irq_a: assert property (state == ST_HALT && !pin_low && !warm_rst_ev
      && !port_wake && (irq_req_in & ~irq_masked) == '0 |=> state == ST_HALT)
      else $error("left halt without a wake source");
   startup_len_a: assert property (state != ST_STARTUP ##1 state == ST_STARTUP
      |-> (state == ST_STARTUP)[*8])
      else $error("start-up wait cut short");
   startup_cnt_a: assert property (state == ST_STARTUP && $past(state) == ST_STARTUP
      && !pin_low |-> seq_cnt == 11'($past(seq_cnt) + 11'h1))
      else $error("start-up counter skipped");
   warm_no_optload_a: assert property (warm_rst_ev && !pin_low
      |=> state == ST_STARTUP)
      else $error("warm reset went through option load");
   pair_forget_a: assert property (clear_hit |=> !seen_first && !seen_second)
      else $error("paired clear progress kept");

   // Wake waits exceed any bounded window, so the pulses at its end are covered alone
   cover_warm_c: cover property (warm_rst_ev ##1 state == ST_STARTUP);
   cover_port_c: cover property (state == ST_HALT && port_wake ##1 state == ST_STARTUP);
   cover_irq_c:  cover property (irq_take_out);
   cover_next_c: cover property (resume_next_out);
   cover_pair_c: cover property (opt_in.paired_clear && clear_hit);

endmodule : wdt_halt_ctrl

/* testbench/wdt_core_model.sv */
// Behavioural core that issues watchdog clear and halt instructions
`timescale 1ns/100ps
module wdt_core_model (
   input  wire logic                clk_sys_in,
   input  wire logic                cpu_run_in,
   output wdt_halt_pkg::cpu_instr_t instr_out
);
   import wdt_halt_pkg::*;

   initial instr_out = '0;

   // Kinds: 0 single clear, 1 first clear, 2 second clear, 3 halt
   task automatic issue(input int kind);
      int n;
      n = 0;
      // Run state is looked at mid-cycle to stay clear of the edge
      @(negedge clk_sys_in);
      while (cpu_run_in !== 1'b1 && n < 4000) begin
         @(negedge clk_sys_in);
         n++;
      end
      @(posedge clk_sys_in);
      instr_out.single_clear <= (kind == 0);
      instr_out.first_clear  <= (kind == 1);
      instr_out.second_clear <= (kind == 2);
      instr_out.halt         <= (kind == 3);
      @(posedge clk_sys_in);
      instr_out <= '0;
      @(negedge clk_sys_in);
   endtask : issue

   task automatic clear(input logic paired);
      if (paired) begin
         issue(1);
         issue(2);
      end else begin
         issue(0);
      end
   endtask : clear
endmodule : wdt_core_model

/* testbench/watchdog_halt_reset_control_tb.sv */
// Self-checking bench for the watchdog, halt and reset controller
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
   $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module watchdog_halt_reset_control_tb;
   import wdt_halt_pkg::*;
   logic       clk_sys_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   reg_req_t   req        = '0;
   opt_t       opt        = '{1'b1, 1'b1, 1'b0, 8'h04};
   cpu_instr_t instr;
   logic       rc_tick    = 1'b0;
   logic       rc_on      = 1'b1;
   logic       ext_n      = 1'b1;
   logic [7:0] pa         = 8'hFF;
   logic [1:0] irq        = '0;
   logic [1:0] irq_en     = '0;
   logic       stack_full = 1'b0;
   logic [7:0] rdata;
   logic [7:0] wreg, treg, ireg, pad, pdir;
   logic       osc_on, run, chip_rst, pcsp, res_next, irq_take, to_f, pd_f;
   int         n_fail = 0;
   int         comparisons = 0;
   int         n_chip = 0, n_warm = 0, n_next = 0, n_irq = 0;

   always #25 clk_sys_in = ~clk_sys_in;
   // RC oscillator tick every second system cycle
   always @(posedge clk_sys_in) rc_tick <= rc_on & ~rc_tick;
   always @(posedge clk_sys_in) begin
      if (chip_rst === 1'b1 && sys_rst_in === 1'b0) n_chip++;
      if (pcsp === 1'b1 && sys_rst_in === 1'b0) n_warm++;
      if (res_next === 1'b1) n_next++;
      if (irq_take === 1'b1) n_irq++;
   end

   wdt_core_model i_core (
      .clk_sys_in (clk_sys_in),
      .cpu_run_in (run),
      .instr_out  (instr)
   );

   wdt_halt_ctrl #(.N_IRQ(2)) i_dut (
      .clk_sys_in                (clk_sys_in),
      .sys_rst_in                (sys_rst_in),
      .reg_req_in                (req),
      .rd_data_out               (rdata),
      .opt_in                    (opt),
      .instr_in                  (instr),
      .rc_tick_in                (rc_tick),
      .ext_reset_n_in            (ext_n),
      .pa_pins_in                (pa),
      .irq_req_in                (irq),
      .irq_enabled_in            (irq_en),
      .stack_full_in             (stack_full),
      .sys_osc_on_out            (osc_on),
      .cpu_run_out               (run),
      .chip_reset_out            (chip_rst),
      .pc_sp_clear_out           (pcsp),
      .resume_next_out           (res_next),
      .irq_take_out              (irq_take),
      .timeout_flag_out          (to_f),
      .powerdown_flag_out        (pd_f),
      .watchdog_control_reg_out  (wreg),
      .timer_control_reg_out     (treg),
      .interrupt_control_reg_out (ireg),
      .pa_data_out               (pad),
      .pa_dir_out                (pdir)
   );

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   function automatic int evts(input int sel);
      return sel == 0 ? n_chip : sel == 1 ? n_warm : sel == 2 ? n_next : n_irq;
   endfunction : evts

   // Cycles until the chosen pulse is seen, -1 on no show
   task automatic wait_evt(input int sel, input int lim, output int cyc);
      int base;
      base = evts(sel);
      cyc = 0;
      while (evts(sel) == base && cyc < lim) begin
         @(posedge clk_sys_in);
         cyc++;
      end
      if (cyc >= lim) cyc = -1;
   endtask : wait_evt

   task automatic wait_run(output int n);
      n = 0;
      while (run !== 1'b1 && n < 1200) begin
         @(posedge clk_sys_in);
         n++;
      end
   endtask : wait_run

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys_in);
      req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys_in);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys_in);
      req.rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask : rd

   // Options only change while reset is held
   task automatic power_up(input opt_t o);
      int n;
      @(posedge clk_sys_in);
      sys_rst_in <= 1'b1;
      opt <= o;
      repeat (10) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      wait_run(n);
      `CHK(n inside {[1036:1048]}, 1'b1)
      `CHK({to_f, pd_f}, 2'b00)
   endtask : power_up

   task automatic pin_reset();
      int n;
      @(posedge clk_sys_in);
      ext_n <= 1'b0;
      repeat (5) @(posedge clk_sys_in);
      ext_n <= 1'b1;
      wait_run(n);
      `CHK(n inside {[1036:1048]}, 1'b1)
   endtask : pin_reset

   initial begin
      repeat (60000) @(posedge clk_sys_in);
      n_fail++;
      report_and_stop();
   end

   initial begin
      int c;
      int b;
      power_up('{1'b1, 1'b1, 1'b0, 8'h04});
      rd(WDT_CTRL_OFF, WDT_CTRL_RST);
      rd(TMR_CTRL_OFF, TMR_CTRL_RST);
      rd(INT_CTRL_OFF, INT_CTRL_RST);
      rd(PA_DATA_OFF, PORT_RST);
      rd(PA_DIR_OFF, PORT_RST);
      `CHK({wreg, treg, ireg, pad, pdir}, {WDT_CTRL_RST, TMR_CTRL_RST, INT_CTRL_RST, PORT_RST, PORT_RST})
      rd(8'h3C, 8'h00);
      wr(RST_FLAGS_OFF, 8'hFF);
      rd(RST_FLAGS_OFF, 8'h00);
      wr(WDT_CTRL_OFF, 8'hFA);
      rd(WDT_CTRL_OFF, 8'hFA);
      wr(PA_DIR_OFF, 8'h00);
      wr(TMR_CTRL_OFF, 8'hFF);
      @(negedge clk_sys_in);
      `CHK({treg, pdir}, {TMR_CTRL_RW_MASK, 8'h00})
      for (int s = 0; s < 3; s++) begin
         wr(WDT_CTRL_OFF, {5'b01010, s[2:0]});
         i_core.clear(1'b0);
         wait_evt(0, 4000, c);
         `CHK(c inside {[(512 << s) - 8 : (512 << s) + 8]}, 1'b1)
         wait_run(c);
         `CHK({to_f, pd_f}, 2'b10)
         rd(WDT_CTRL_OFF, WDT_CTRL_RST);
         rd(PA_DIR_OFF, PORT_RST);
         `CHK({treg, pdir}, {TMR_CTRL_RST, PORT_RST})
      end
      // Regular clears well inside the 512-cycle window
      b = n_chip;
      wr(WDT_CTRL_OFF, 8'h00);
      for (int k = 0; k < 5; k++) begin
         i_core.clear(1'b0);
         repeat (400) @(posedge clk_sys_in);
      end
      `CHK(n_chip, b)
      i_core.issue(3);
      `CHK({to_f, pd_f, osc_on, run}, 4'b0100)
      wr(WDT_CTRL_OFF, 8'h33);
      rd(WDT_CTRL_OFF, 8'h00);
      pa <= 8'hFB;
      wait_evt(2, 1200, c);
      pa <= 8'hFF;
      `CHK(c inside {[1022:1030]}, 1'b1)
      `CHK({to_f, pd_f}, 2'b01)
      i_core.clear(1'b0);
      `CHK(pd_f, 1'b0)
      b = n_chip;
      wr(WDT_CTRL_OFF, 8'hA0);
      i_core.issue(3);
      wait_evt(1, 700, c);
      `CHK(c inside {[500:520]}, 1'b1)
      wait_run(c);
      `CHK(c inside {[1020:1030]}, 1'b1)
      `CHK({to_f, pd_f}, 2'b11)
      `CHK(n_chip, b)
      rd(WDT_CTRL_OFF, 8'hA0);
      `CHK(wreg, 8'hA0)
      pin_reset();
      `CHK({to_f, pd_f}, 2'b11)
      rd(WDT_CTRL_OFF, WDT_CTRL_RST);
      i_core.issue(3);
      pin_reset();
      `CHK({to_f, pd_f}, 2'b01)
      // A request pending at halt must not wake
      irq_en <= 2'b11;
      irq <= 2'b01;
      i_core.issue(3);
      repeat (100) @(posedge clk_sys_in);
      `CHK(run, 1'b0)
      irq <= 2'b11;
      wait_evt(3, 1200, c);
      `CHK(c inside {[1022:1032]}, 1'b1)
      for (int k = 0; k < 2; k++) begin
         irq <= 2'b00;
         irq_en <= k ? 2'b11 : 2'b01;
         stack_full <= k[0];
         i_core.issue(3);
         irq <= 2'b10;
         wait_evt(2, 1200, c);
         `CHK(c > 0, 1'b1)
      end
      irq <= 2'b00;
      rc_on <= 1'b0;
      power_up('{1'b1, 1'b0, 1'b0, 8'h04});
      wr(WDT_CTRL_OFF, 8'h00);
      i_core.clear(1'b0);
      wait_evt(0, 1500, c);
      `CHK(c inside {[1016:1032]}, 1'b1)
      wait_run(c);
      b = n_warm;
      c = n_next;
      wr(WDT_CTRL_OFF, 8'h00);
      i_core.issue(3);
      pa <= 8'hFE;
      repeat (2000) @(posedge clk_sys_in);
      `CHK(n_warm, b)
      `CHK(n_next, c)
      pa <= 8'hFA;
      wait_evt(2, 1200, c);
      `CHK(c > 0, 1'b1)
      pa <= 8'hFF;
      rc_on <= 1'b1;
      power_up('{1'b1, 1'b1, 1'b1, 8'h04});
      b = n_chip;
      wr(WDT_CTRL_OFF, 8'h00);
      for (int k = 0; k < 4; k++) begin
         i_core.issue(1);
         repeat (300) @(posedge clk_sys_in);
         i_core.issue(2);
         repeat (100) @(posedge clk_sys_in);
      end
      `CHK(n_chip, b)
      // Lone single clears do nothing in paired mode
      for (int k = 0; k < 2; k++) begin
         repeat (200) @(posedge clk_sys_in);
         i_core.issue(0);
      end
      wait_evt(0, 300, c);
      `CHK(c > 0, 1'b1)
      power_up('{1'b0, 1'b1, 1'b0, 8'h04});
      b = n_chip;
      wr(WDT_CTRL_OFF, 8'h00);
      i_core.clear(1'b0);
      repeat (1500) @(posedge clk_sys_in);
      `CHK(n_chip, b)
      report_and_stop();
   end
endmodule : watchdog_halt_reset_control_tb
